//--- hdl/lsc_bc_unpack.v
// Spreads the GPIO samples of one back-channel frame over the frame time.
`timescale 1ns/1ps
`include "lsc_defines.vh"
module lsc_bc_unpack (
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_n,
  // Accepted frame and link settings.
  input  wire        frame_ok,
  input  wire [23:0] frame_bits,
  input  wire [2:0]  mode,
  input  wire        rate_fast,
  // Regenerated GPIO levels.
  output reg  [3:0]  gpio_q
);
  reg [23:0] buf_q;   // Samples still to be played, oldest in the low bits.
  reg [3:0]  left_q;  // Samples left in this frame.
  reg [4:0]  tmr_q;   // Cycles to the next sample.
  reg [3:0]  nsamp;   // Samples per frame for the mode.
  reg [2:0]  width;   // Bits per sample for the mode.
  // ==================================================================
  // Samples per frame and bits per sample of each mode.
  always @* begin
    case (mode)
      `LSC_MODE_NORMAL: begin nsamp = `LSC_SPF_NORMAL; width = 3'd4; end
      `LSC_MODE_FAST4:  begin nsamp = `LSC_SPF_FAST4;  width = 3'd4; end
      `LSC_MODE_FAST2:  begin nsamp = `LSC_SPF_FAST2;  width = 3'd2; end
      `LSC_MODE_FAST1:  begin nsamp = `LSC_SPF_FAST1;  width = 3'd1; end
      default:          begin nsamp = 4'd0;  width = 3'd0; end
    endcase
  end
  // ==================================================================
  // One sample per bit time; pins not carried in a mode hold their level.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= 24'h000000;  left_q <= 4'h0;  tmr_q <= 5'h00;  gpio_q <= 4'h0;
    end else if (frame_ok) begin
      buf_q <= frame_bits;  left_q <= nsamp;  tmr_q <= 5'h00;
    end else if (left_q != 4'h0) begin
      if (tmr_q == 5'h00) begin
        if (width == 3'd4) gpio_q <= buf_q[3:0];
        else if (width == 3'd2) gpio_q[1:0] <= buf_q[1:0];
        else gpio_q[0] <= buf_q[0];
        buf_q  <= buf_q >> width;
        left_q <= left_q - 4'h1;
        tmr_q  <= (rate_fast ? `LSC_BC_STEP_FAST : `LSC_BC_STEP_SLOW) - 5'd1;
      end else begin
        tmr_q <= tmr_q - 5'd1;
      end
    end
  end
endmodule

//--- hdl/lsc_i2c_slave.v
// I2C slave that turns bus traffic into register read and write strobes.
`timescale 1ns/1ps
`include "lsc_defines.vh"
module lsc_i2c_slave (
  // Clock and reset.
  input  wire       sys_clk,
  input  wire       rst_n,
  // I2C pins.
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // Address enables.
  input  wire       second_en,
  // Register access.
  output reg  [7:0] reg_addr,
  output reg  [7:0] wr_data,
  output reg        wr_stb,
  output reg        rd_stb,
  output reg        hit_second,
  input  wire [7:0] rd_data
);
  // States of the byte engine.
  localparam ST_IDLE = 4'd0;
  localparam ST_ADDR = 4'd1;
  localparam ST_ACKA = 4'd2;
  localparam ST_PTR  = 4'd3;
  localparam ST_ACKP = 4'd4;
  localparam ST_WDAT = 4'd5;
  localparam ST_ACKW = 4'd6;
  localparam ST_RDAT = 4'd7;
  localparam ST_RACK = 4'd8;
  reg [2:0] scl_s;     // Synchroniser and history for the clock pin.
  reg [2:0] sda_s;     // Synchroniser and history for the data pin.
  reg [3:0] state_q;   // Byte engine state.
  reg [3:0] cnt_q;     // Bit counter within a byte.
  reg [7:0] sr_q;      // Shift register.
  reg       rw_q;      // Transfer direction, 1 for read.
  reg       nack_q;    // Master refused the last read byte.
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start    = scl_s[1] & ~sda_s[1] & sda_s[2];
  wire stop     = scl_s[1] & sda_s[1] & ~sda_s[2];
  wire hit_main = (sr_q[7:1] == `LSC_I2C_ADDR_MAIN);
  wire hit_two  = second_en & (sr_q[7:1] == `LSC_I2C_ADDR_SECOND);
  // ==================================================================
  // Pins pass two flops before the edge detectors read stage two.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end
  // ==================================================================
  // Byte engine: sample on the rising clock edge, act on the falling one.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;  cnt_q <= 4'h0;  sr_q <= 8'h00;
      rw_q <= 1'b0;  nack_q <= 1'b0;  sda_out <= 1'b0;  sda_oe <= 1'b0;
      reg_addr <= 8'h00;  wr_data <= 8'h00;  wr_stb <= 1'b0;
      rd_stb <= 1'b0;  hit_second <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start) begin
        state_q <= ST_ADDR;  cnt_q <= 4'h0;  sda_oe <= 1'b0;
      end else if (stop) begin
        state_q <= ST_IDLE;  sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WDAT) begin
          sr_q  <= {sr_q[6:0], sda_s[1]};
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_RACK) begin
          nack_q <= sda_s[1];
        end
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (cnt_q == 4'h8) begin
              // Answer only our own addresses.
              if (hit_main | hit_two) begin
                sda_oe <= 1'b1;  rw_q <= sr_q[0];  hit_second <= hit_two;
                state_q <= ST_ACKA;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACKA: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              // Load the first read byte and drive its top bit.
              sr_q <= rd_data;  sda_oe <= ~rd_data[7];  rd_stb <= 1'b1;
              state_q <= ST_RDAT;
            end else begin
              sda_oe <= 1'b0;  state_q <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (cnt_q == 4'h8) begin
              reg_addr <= sr_q;  sda_oe <= 1'b1;  state_q <= ST_ACKP;
            end
          end
          ST_ACKP, ST_ACKW: begin
            if (state_q == ST_ACKW) reg_addr <= reg_addr + 8'h01;
            sda_oe <= 1'b0;  cnt_q <= 4'h0;  state_q <= ST_WDAT;
          end
          ST_WDAT: begin
            if (cnt_q == 4'h8) begin
              wr_data <= sr_q;  wr_stb <= 1'b1;  sda_oe <= 1'b1;
              state_q <= ST_ACKW;
            end
          end
          ST_RDAT: begin
            if (cnt_q == 4'h7) begin
              sda_oe <= 1'b0;  reg_addr <= reg_addr + 8'h01;  state_q <= ST_RACK;
            end else begin
              sr_q <= {sr_q[6:0], 1'b0};  sda_oe <= ~sr_q[6];  cnt_q <= cnt_q + 4'h1;
            end
          end
          ST_RACK: begin
            if (nack_q) begin
              state_q <= ST_IDLE;
            end else begin
              sr_q <= rd_data;  sda_oe <= ~rd_data[7];  rd_stb <= 1'b1;
              cnt_q <= 4'h0;  state_q <= ST_RDAT;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

//--- hdl/lsc_top.v
// Sideband control of a serializer bridge: port registers, interrupts, GPIO.
// Behaviour
// R1 - Accept back-channel frames at 5 or 20 Mbps
// R2 - Read returns selected port, second wins if both
// R3 - Write updates every selected port copy
// R4 - Shared registers ignore the port select bits
// R5 - Second address reaches second port, ignores selects
// R6 - Power-down resets all control registers to default
// R7 - Host holds power-down low at least 3 ms
// R8 - Any fault clears link-detect bit zero of status
// R9 - All fault kinds reported as one common bit
// R10 - Host sets control bits five and zero
// R11 - Remote interrupt low drives interrupt output low
// R12 - Reading source status clears pending, releases output
// R13 - Host clears remote source; next fall re-arms
// R14 - Mirror output follows remote level, no clearing
// R15 - Mirror output high while no link exists
// R16 - Port selects steer GPIO configuration registers
// R17 - Second-lane GPIO only in two-lane mode
// R18 - Field 3 sends pin forward, 5 drives from back
// R19 - Deserializer configured the complementary way
// R20 - Sampling modes 000, 011, 010, 001 supported
// R21 - Deserializer chooses rate and mode; device follows
// R22 - Deserializer mode field sits in its own register
// R23 - Power-down resets asynchronously, released synchronously
`timescale 1ns/1ps
`include "lsc_defines.vh"
module lsc_top (
  // Clock, reset and power-down pin.
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        power_down_n,
  // I2C register port.
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  // Link state from the serial front end.
  input  wire [1:0]  link_fault,
  input  wire        dual_lane_active,
  // Back-channel frames, one stream per port.
  input  wire [1:0]  bc_frame_valid,
  input  wire [1:0]  bc_crc_ok,
  input  wire [47:0] bc_gpio_bits,
  input  wire [1:0]  bc_remote_irq_n,
  input  wire [2:0]  fast_control_mode,
  input  wire        bc_rate_fast,
  // Primary GPIO pins.
  input  wire [3:0]  gpio_in,
  output wire [3:0]  gpio_out,
  output wire [3:0]  gpio_oe,
  // Second-lane GPIO pins.
  input  wire [3:0]  d_gpio_in,
  output wire [3:0]  d_gpio_out,
  output wire [3:0]  d_gpio_oe,
  // GPIO levels sent on the forward channel, second lane in the top half.
  output reg  [7:0]  fwd_gpio_q,
  // Interrupt outputs.
  output reg         irq_out_n,
  output reg         remote_irq_mirror_n
);
  // ==================================================================
  // Internal reset.
  wire       rst_any_n = rst_n & power_down_n;  // Either pin holds the block.
  reg  [1:0] rst_sync_q;                        // Release synchroniser.
  wire       srst_n = rst_sync_q[1];            // Reset used by all logic.
  // Assert at once, release two edges later so no flop sees a runt.
  always @(posedge sys_clk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rst_sync_q <= 2'b00; // R6 R23
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1}; // R23
    end
  end
  // ==================================================================
  // Pin synchronisers.
  reg [1:0] fault_s1;     // First stage of fault inputs.
  reg [1:0] fault_s2;     // Synchronised fault inputs.
  reg [7:0] gpin_s1;      // First stage of GPIO pins.
  reg [7:0] gpin_s2;      // Synchronised GPIO pins, second lane on top.
  // Every asynchronous pin passes two flops before use.
  always @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      fault_s1 <= 2'b11;
      fault_s2 <= 2'b11;
      gpin_s1  <= 8'h00;
      gpin_s2  <= 8'h00;
    end else begin
      fault_s1 <= link_fault;
      fault_s2 <= fault_s1;
      gpin_s1  <= {d_gpio_in, gpio_in};
      gpin_s2  <= gpin_s1;
    end
  end
  // ==================================================================
  // Register access engine.
  wire [7:0] reg_addr;    // Current register pointer.
  wire [7:0] wr_data;     // Byte being written.
  wire       wr_stb;      // Write strobe, one cycle.
  wire       rd_stb;      // Read strobe, one cycle when a byte is loaded.
  wire       hit_second;  // Transfer came in on the second address.
  reg  [7:0] rd_data;     // Read mux.
  reg  [7:0] sel_q;       // Port select register.
  lsc_i2c_slave u_i2c (
    .sys_clk    (sys_clk),
    .rst_n      (srst_n),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .second_en  (sel_q[`LSC_SEL_SECOND_ADDR]),
    .reg_addr   (reg_addr),
    .wr_data    (wr_data),
    .wr_stb     (wr_stb),
    .rd_stb     (rd_stb),
    .hit_second (hit_second),
    .rd_data    (rd_data)
  );
  // ==================================================================
  // Port steering.
  wire       sec_addr = sel_q[`LSC_SEL_SECOND_ADDR];
  // With the second address on, the address alone picks the port.
  wire       rd_port  = sec_addr ? hit_second : sel_q[`LSC_SEL_SECOND]; // R2 R5
  wire [1:0] wr_mask  = sec_addr ? {hit_second, ~hit_second} :
                                   {sel_q[`LSC_SEL_SECOND], sel_q[`LSC_SEL_FIRST]}; // R3 R5
  // ==================================================================
  // Shared registers: select and interrupt control.
  reg  [7:0] irq_ctl_q;   // Interrupt control register.
  reg        pend_q;      // Remote interrupt pending.
  reg        rem_lvl_q;   // Remote interrupt level seen over the link.
  reg        rem_prev_q;  // Previous level, for the falling edge.
  wire       linked;      // Primary port has a working link.
  wire       rem_fall = rem_prev_q & ~rem_lvl_q;
  wire       rem_en   = irq_ctl_q[`LSC_IRQ_REMOTE_EN] & irq_ctl_q[`LSC_IRQ_GLOBAL_EN];
  wire       src_read = rd_stb & (reg_addr == `LSC_OFS_IRQ_SOURCE);
  // Shared registers are written whatever the port selects hold.
  always @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      sel_q     <= `LSC_RST_SELECT; // R6
      irq_ctl_q <= `LSC_RST_CONTROL; // R6
    end else if (wr_stb) begin
      if (reg_addr == `LSC_OFS_PORT_SELECT) sel_q <= wr_data; // R4 R16
      if (reg_addr == `LSC_OFS_IRQ_CONTROL) irq_ctl_q <= wr_data; // R4
    end
  end
  // ==================================================================
  // Remote interrupt: level from accepted frames, sticky on falling edge.
  // A new edge in the cycle of a source read wins over the clear.
  always @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      rem_lvl_q  <= 1'b1;
      rem_prev_q <= 1'b1;
      pend_q     <= 1'b0;
    end else begin
      if (!linked) begin
        rem_lvl_q <= 1'b1; // R15
      end else if (bc_frame_valid[0] & bc_crc_ok[0]) begin
        rem_lvl_q <= bc_remote_irq_n[0]; // R1 R14
      end
      rem_prev_q <= rem_lvl_q;
      if (rem_en & rem_fall) begin
        pend_q <= 1'b1; // R11 R13
      end else if (src_read) begin
        pend_q <= 1'b0; // R12
      end
    end
  end
  // Interrupt and mirror outputs come from flops.
  always @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      irq_out_n           <= 1'b1;
      remote_irq_mirror_n <= 1'b1;
    end else begin
      irq_out_n           <= ~(pend_q & rem_en); // R11 R12
      remote_irq_mirror_n <= linked ? rem_lvl_q : 1'b1; // R14 R15
    end
  end
  // ==================================================================
  // Per-port registers, GPIO handling and back-channel unpacking.
  wire [15:0] cfg_lo;     // GPIO0 config byte of each port.
  wire [15:0] cfg_mid;    // GPIO1 and GPIO2 config byte of each port.
  wire [15:0] cfg_hi;     // GPIO3 config byte of each port.
  wire [1:0]  link_ok;    // Link detect of each port.
  wire [7:0]  bc_gpio;    // Back-channel GPIO levels, second lane on top.
  wire [7:0]  pin_out;    // Pin levels driven from back channel.
  wire [7:0]  pin_oe;     // Pin enables.
  wire [7:0]  fwd_d;      // Forward levels before the output flop.
  assign linked = link_ok[0];
  genvar p;
  genvar b;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      reg  [7:0]  lo_q;     // GPIO0 config copy.
      reg  [7:0]  mid_q;    // GPIO1 and GPIO2 config copy.
      reg  [7:0]  hi_q;     // GPIO3 config copy.
      wire [15:0] fields = {hi_q[3:0], mid_q[7:4], mid_q[3:0], lo_q[3:0]};
      // The second lane is usable only in two-lane operation.
      wire        lane_on = (p == 0) ? 1'b1 : dual_lane_active; // R17
      // Each copy takes a write only when its port is selected, or with the second address on, only when its address is used.
      always @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
          lo_q  <= `LSC_RST_CFG; // R6
          mid_q <= `LSC_RST_CFG;
          hi_q  <= `LSC_RST_CFG;
        end else if (wr_stb & wr_mask[p]) begin
          if (reg_addr == `LSC_OFS_GPIO0_CFG)  lo_q  <= wr_data; // R3 R16
          if (reg_addr == `LSC_OFS_GPIO12_CFG) mid_q <= wr_data; // R3 R16
          if (reg_addr == `LSC_OFS_GPIO3_CFG)  hi_q  <= wr_data; // R3 R16
        end
      end
      assign cfg_lo[8*p+7:8*p]  = lo_q;
      assign cfg_mid[8*p+7:8*p] = mid_q;
      assign cfg_hi[8*p+7:8*p]  = hi_q;
      // Any of the fault kinds shows only as a cleared detect bit.
      assign link_ok[p] = ~fault_s2[p]; // R8 R9
      // Frames failing their check are dropped; mode and rate are followed.
      lsc_bc_unpack u_unpack (
        .sys_clk    (sys_clk),
        .rst_n      (srst_n),
        .frame_ok   (bc_frame_valid[p] & bc_crc_ok[p]), // R1
        .frame_bits (bc_gpio_bits[24*p+23:24*p]),
        .mode       (fast_control_mode), // R20 R21
        .rate_fast  (bc_rate_fast), // R1 R21
        .gpio_q     (bc_gpio[4*p+3:4*p])
      );
      for (b = 0; b < 4; b = b + 1) begin : g_bit
        wire [3:0] f = fields[4*b+3:4*b];
        // Code 3 forwards the pin, code 5 drives it from the back channel.
        assign fwd_d[4*p+b]   = lane_on & (f == `LSC_GPIO_FORWARD) &
                                gpin_s2[4*p+b]; // R18
        assign pin_oe[4*p+b]  = lane_on & (f == `LSC_GPIO_BACK); // R18 R17
        assign pin_out[4*p+b] = bc_gpio[4*p+b]; // R18
      end
    end
  endgenerate
  assign gpio_out   = pin_out[3:0];
  assign gpio_oe    = pin_oe[3:0];
  assign d_gpio_out = pin_out[7:4];
  assign d_gpio_oe  = pin_oe[7:4];
  // Forward levels are registered for the frame builder.
  always @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      fwd_gpio_q <= 8'h00;
    end else begin
      fwd_gpio_q <= fwd_d;
    end
  end
  // ==================================================================
  // Read mux; unmapped offsets read zero.
  always @* begin
    case (reg_addr)
      `LSC_OFS_LINK_STATUS: rd_data = {7'h00, link_ok[rd_port]}; // R2 R8
      `LSC_OFS_GPIO0_CFG:   rd_data = rd_port ? cfg_lo[15:8]  : cfg_lo[7:0]; // R2
      `LSC_OFS_GPIO12_CFG:  rd_data = rd_port ? cfg_mid[15:8] : cfg_mid[7:0]; // R2
      `LSC_OFS_GPIO3_CFG:   rd_data = rd_port ? cfg_hi[15:8]  : cfg_hi[7:0]; // R2
      `LSC_OFS_PORT_SELECT: rd_data = sel_q; // R4
      `LSC_OFS_IRQ_CONTROL: rd_data = irq_ctl_q; // R4
      `LSC_OFS_IRQ_SOURCE:  rd_data = {7'h00, pend_q}; // R12
      default:              rd_data = 8'h00;
    endcase
  end
endmodule

//--- inc/lsc_defines.vh
// Constants for the link sideband control block: map, fields, resets and timing.
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH
// ==================================================================
// Register offsets.
`define LSC_OFS_LINK_STATUS  8'h0C
`define LSC_OFS_GPIO0_CFG    8'h0D
`define LSC_OFS_GPIO12_CFG   8'h0E
`define LSC_OFS_GPIO3_CFG    8'h0F
`define LSC_OFS_PORT_SELECT  8'h1E
`define LSC_OFS_IRQ_CONTROL  8'hC6
`define LSC_OFS_IRQ_SOURCE   8'hC7
// ==================================================================
// Field positions and reset values.
`define LSC_SEL_FIRST        0
`define LSC_SEL_SECOND       1
`define LSC_SEL_SECOND_ADDR  3
`define LSC_IRQ_GLOBAL_EN    0
`define LSC_IRQ_REMOTE_EN    5
`define LSC_SRC_REMOTE       0
`define LSC_RST_SELECT       8'h01
`define LSC_RST_CFG          8'h00
`define LSC_RST_CONTROL      8'h00
// ==================================================================
// GPIO field codes.
`define LSC_GPIO_FORWARD     4'h3
`define LSC_GPIO_BACK        4'h5
// ==================================================================
// I2C slave addresses, 7 bits; values are arbitrary.
`define LSC_I2C_ADDR_MAIN    7'h0C
`define LSC_I2C_ADDR_SECOND  7'h0D
// ==================================================================
// Sampling mode codes chosen by the deserializer.
`define LSC_MODE_NORMAL      3'h0
`define LSC_MODE_FAST4       3'h3
`define LSC_MODE_FAST2       3'h2
`define LSC_MODE_FAST1       3'h1
// Samples carried per back-channel frame in each sampling mode.
`define LSC_SPF_NORMAL       4'd1
`define LSC_SPF_FAST4        4'd6
`define LSC_SPF_FAST2        4'd10
`define LSC_SPF_FAST1        4'd15
// Clock cycles per back-channel bit time at 100 MHz (5 and 20 Mbps).
`define LSC_BC_STEP_SLOW     5'd20
`define LSC_BC_STEP_FAST     5'd5
`endif

//--- verification/lsc_checker.sv
// Port assertions for the link sideband control block.
`timescale 1ns/1ps
module lsc_checker (
  // Clock, resets and watched pins.
  input wire        sys_clk, rst_n, power_down_n, sda_oe,
  input wire [1:0]  link_fault, bc_frame_valid, bc_crc_ok,
  input wire        dual_lane_active, irq_out_n, remote_irq_mirror_n,
  input wire [47:0] bc_gpio_bits,
  input wire [2:0]  fast_control_mode,
  input wire [3:0]  gpio_out, gpio_oe, d_gpio_oe,
  input wire [7:0]  fwd_gpio_q
);
  // Either reset source sets the gap counter to its saturated value.
  wire any_rst_n = rst_n & power_down_n;
  reg  [8:0] gap_q;
  // Cycles since the last accepted port-0 frame, saturating.
  always @(posedge sys_clk or negedge any_rst_n) begin
    if (!any_rst_n) gap_q <= 9'h1FF;
    else if (bc_frame_valid[0] && bc_crc_ok[0]) gap_q <= 9'h000;
    else if (gap_q != 9'h1FF) gap_q <= gap_q + 9'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_frame0; bc_frame_valid[0] && bc_crc_ok[0]; endsequence
  sequence s_no_link; link_fault[0] [*6]; endsequence
  a_pd_quiet: assert property (!power_down_n |-> irq_out_n && remote_irq_mirror_n
    && !sda_oe && gpio_oe == 4'h0 && fwd_gpio_q == 8'h00) else $error("active in power-down");
  a_release_sync: assert property ($rose(power_down_n) |-> irq_out_n ##1 irq_out_n)
    else $error("interrupt right after release");
  a_mirror_no_link: assert property (s_no_link |-> remote_irq_mirror_n)
    else $error("mirror low without link");
  a_irq_cause: assert property ($fell(irq_out_n) |-> !remote_irq_mirror_n)
    else $error("interrupt without remote low");
  a_dlane_gate: assert property (!dual_lane_active |-> d_gpio_oe == 4'h0)
    else $error("second lane driven in one-lane mode");
  a_fwd_quiet: assert property ((fwd_gpio_q[3:0] & gpio_oe & $past(gpio_oe)) == 4'h0)
    else $error("forward level on a back-channel pin");
  a_out_after_frame: assert property (disable iff (!any_rst_n)
    $changed(gpio_out) |-> gap_q <= 9'd302) else $error("pin change without frame");
  a_first_sample: assert property (disable iff (!any_rst_n)
    s_frame0 ##0 fast_control_mode == 3'h0 |-> ##2 gpio_out == $past(bc_gpio_bits[3:0], 2))
    else $error("normal mode sample wrong");
endmodule
bind lsc_top lsc_checker i_lsc_checker (.sys_clk, .rst_n, .power_down_n, .sda_oe, .link_fault,
  .bc_frame_valid, .bc_crc_ok, .dual_lane_active, .irq_out_n, .remote_irq_mirror_n,
  .bc_gpio_bits, .fast_control_mode, .gpio_out, .gpio_oe, .d_gpio_oe, .fwd_gpio_q);

//--- verification/lsc_far_model.sv
// Behavioural deserializer that sends back-channel frames.
`timescale 1ns/1ps
module lsc_far_model (
  // Clock.
  input  wire        sys_clk,
  // Back-channel frame outputs.
  output reg  [1:0]  bc_frame_valid = 2'h0,
  output reg  [1:0]  bc_crc_ok = 2'h0,
  output reg  [47:0] bc_gpio_bits = 48'h0,
  output reg  [1:0]  bc_remote_irq_n = 2'h3,
  output reg  [2:0]  fast_control_mode = 3'h0,
  output reg         bc_rate_fast = 1'b0
);
  // The far end alone picks line rate and sampling mode.
  task set_mode(input [2:0] m, input f);
    fast_control_mode = m;
    bc_rate_fast = f;
  endtask
  // One good frame; the data lines scramble once the frame ends.
  task send(input p, input [23:0] g, input irq_n);
    @(posedge sys_clk); #1;
    bc_frame_valid[p] = 1'b1;
    bc_crc_ok[p] = 1'b1;
    bc_gpio_bits[24*p +: 24] = g;
    bc_remote_irq_n[p] = irq_n;
    @(posedge sys_clk); #1;
    bc_frame_valid = 2'h0;
    bc_crc_ok = 2'h0;
    bc_gpio_bits = ~bc_gpio_bits;
  endtask
endmodule

//--- verification/lsc_top_bench.sv
// Self-checking testbench of the link sideband control block.
`timescale 1ns/1ps
`include "lsc_defines.vh"
module lsc_top_bench;
  reg sys_clk = 1'b0, rst_n = 1'b0, power_down_n = 1'b1, scl_in = 1'b1, sda_drv = 1'b1;
  reg dual_lane_active = 1'b0, ack, a2;
  reg [1:0] link_fault = 2'h0;
  reg [3:0] gpio_in = 4'h1, d_gpio_in = 4'h0;
  reg [7:0] rv;
  integer errors = 0, tests_run = 0, i, j;
  wire sda_oe, sda_out, irq_out_n, remote_irq_mirror_n, bc_rate_fast;
  wire sda_in = sda_drv & ~sda_oe;
  wire [1:0] bc_frame_valid, bc_crc_ok, bc_remote_irq_n;
  wire [47:0] bc_gpio_bits;
  wire [2:0] fast_control_mode;
  wire [3:0] gpio_out, gpio_oe, d_gpio_out, d_gpio_oe;
  wire [7:0] fwd_gpio_q;
  // Mode, expected final level and pin mask for each sampling mode; the rate follows bit zero of the index.
  localparam [11:0] MODES = {3'h1, 3'h2, 3'h3, 3'h0};
  localparam [15:0] EXPS = {4'h0, 4'h3, 4'h5, 4'h6}, MASKS = {4'h1, 4'h3, 4'hF, 4'hF};
  lsc_top i_lsc_top (.*);
  lsc_far_model i_lsc_far_model (.*);
  always #5 sys_clk = ~sys_clk;
  task cyc(input integer n); repeat (n) @(posedge sys_clk); #1; endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    tests_run++;
    if (g !== e) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end
  endtask
  // One I2C bit: data set while SCL is low, read back mid-high.
  task bit_io(input b, output r);
    sda_drv = b; cyc(6); scl_in = 1'b1; cyc(6); r = sda_in; cyc(6); scl_in = 1'b0; cyc(6);
  endtask
  task byte_io(input [7:0] d, output a);
    for (j = 0; j < 8; j++) bit_io(d[7-j], rv[7-j]);
    bit_io(1'b1, a); a = !a;
  endtask
  task start; sda_drv = 1; cyc(6); scl_in = 1; cyc(6); sda_drv = 0; cyc(6); scl_in = 0; cyc(6);
  endtask
  // Whole register access; the read byte is left in rv, address ack in ack.
  task acc(input [6:0] dev, input [7:0] p, input [7:0] d, input w);
    start; byte_io({dev, 1'b0}, ack);
    if (ack) begin
      byte_io(p, a2);
      if (w) byte_io(d, a2);
      else begin start; byte_io({dev, 1'b1}, a2); byte_io(8'hFF, a2); end
    end
    sda_drv = 0; cyc(6); scl_in = 1; cyc(6); sda_drv = 1; cyc(6);
  endtask
  task wr(input [7:0] p, input [7:0] d); acc(`LSC_I2C_ADDR_MAIN, p, d, 1'b1); endtask
  task rd(input [7:0] p, input [7:0] e, input string nm);
    acc(`LSC_I2C_ADDR_MAIN, p, 8'h00, 1'b0); chk(nm, e, rv);
  endtask
  task finish_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog for a hung run.
  initial begin #900000; errors++; finish_test; end
  initial begin
    cyc(3); rst_n = 1; cyc(5);
    rd(8'h1E, 8'h01, "select"); rd(8'h0D, 8'h00, "gpio0 cfg"); rd(8'hC6, 8'h00, "irq ctl");
    wr(8'h0D, 8'h03); wr(8'h1E, 8'h02); rd(8'h0D, 8'h00, "port1 copy");
    wr(8'h0D, 8'h05); wr(8'h1E, 8'h03); rd(8'h0D, 8'h05, "both picked");
    wr(8'h0E, 8'h55); wr(8'h1E, 8'h00); rd(8'h0E, 8'h55, "port0 copy");
    wr(8'hC6, 8'h21); rd(8'hC6, 8'h21, "shared");
    chk("oe", 8'h06, {d_gpio_oe, gpio_oe}); chk("fwd", 8'h01, fwd_gpio_q);
    dual_lane_active = 1; cyc(2); chk("oe dual", 8'h76, {d_gpio_oe, gpio_oe});
    acc(`LSC_I2C_ADDR_SECOND, 8'h0D, 8'h00, 1'b0); chk("no second", 8'h00, {6'h0, sda_out, ack});
    wr(8'h1E, 8'h09); acc(`LSC_I2C_ADDR_SECOND, 8'h0D, 8'h00, 1'b0);
    chk("second", 8'h05, rv); rd(8'h0D, 8'h03, "main");
    for (i = 0; i < 4; i++) begin
      i_lsc_far_model.set_mode(MODES[i*3 +: 3], i[0]); cyc(2);
      i_lsc_far_model.send(1'b0, 24'h5C3A96, 1'b1);
      i_lsc_far_model.send(1'b1, 24'h5C3A96, 1'b1); cyc(310);
      chk("bc level", {2{EXPS[i*4+:4]}}, {d_gpio_out, gpio_out} & {2{MASKS[i*4+:4]}});
    end
    i_lsc_far_model.send(1'b0, 24'h0, 1'b0); cyc(6);
    chk("irq", 8'h00, {irq_out_n, remote_irq_mirror_n});
    rd(8'hC7, 8'h01, "source"); chk("clear", 8'h02, {irq_out_n, remote_irq_mirror_n});
    i_lsc_far_model.send(1'b0, 24'h0, 1'b1); cyc(6); chk("mirror", 8'h03, {irq_out_n, remote_irq_mirror_n});
    i_lsc_far_model.send(1'b0, 24'h0, 1'b0); cyc(6); chk("rearm", 8'h00, {irq_out_n, remote_irq_mirror_n});
    link_fault = 2'h1; cyc(8); chk("no link", 8'h01, {7'h0, remote_irq_mirror_n});
    rd(8'h0C, 8'h00, "fault"); link_fault = 2'h0; cyc(4); rd(8'h0C, 8'h01, "linked");
    link_fault = 2'h2; cyc(4); acc(`LSC_I2C_ADDR_SECOND, 8'h0C, 8'h00, 1'b0); chk("fault1", 8'h00, rv);
    // The power-down hold is shortened to keep the run short; the block does not time it.
    power_down_n = 0; cyc(5); chk("pd", 8'h03, {irq_out_n, remote_irq_mirror_n});
    power_down_n = 1; cyc(5); rd(8'h1E, 8'h01, "select pd"); rd(8'hC6, 8'h00, "ctl pd");
    finish_test;
  end
endmodule
